/* shared/bst_pkg.sv */
// Constants, types and register map of the batch sequencer and flow totaliser.
// Assumes one 20 MHz clock, an APB master with 32-bit data, synchronous inputs.
// Summary of operation
// - End-of-batch output turns on at end of batch and stays on until STOP or auto restart.
// - Auto restart waits a programmed time after end of batch, then starts anew.
// - In auto mode STOP pauses, RUN resumes, second STOP aborts, RUN restarts.
// - A configuration bit enables or disables overrun compensation.
// - Overrun is batch total after flow stops minus set batch quantity.
// - Average of last three overruns is subtracted from the next target.
// - After relays drop, overrun is measured until the signal timeout fires.
// - Rate is span times input, its square root or its power, plus zero.
// - Analog input is normalised to 0 at minimum and 1 at maximum signal.
// - Span accepted from 0.1000 to 50000.0000, zero from 0.0000 to 50000.0000.
// - No integration into totals while rate is below the cutoff fraction.
// - Rate filter constant 1 means no filtering, largest constant is 99.
// - Filter response slows as the constant grows.
// - All totals are divided by the total division factor, 0.01 to 2000.
// - One output pulse per least significant digit of accumulated total.
// - Output pulse is active low about 10 ms, at most 49 per second.
// - Flow alarm when no flow longer than timeout in a batch, timeout nonzero.
// - Alarm output low while alarm exists, released high by STOP.
// - Flow is stopped after no input beyond the timeout; 0 disables, max 99 s.
// - End of batch needs quantity, stopped flow and timeout; zero timeout skips.
// - Flow alarm or STOP during a batch drops both relays at once.
package bst_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned SEC_MS        = 1000;
  localparam int unsigned SAMPLE_MS     = 100;
  localparam int unsigned PULSE_LOW_MS  = 10;
  localparam int unsigned PULSE_MAX_HZ  = 49;
  localparam int unsigned SEC_CYC       = CLK_HZ / 1000 * SEC_MS;
  localparam int unsigned SAMPLE_CYC    = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int unsigned PULSE_LOW_CYC = CLK_HZ / 1000 * PULSE_LOW_MS;
  localparam int unsigned PULSE_PER_CYC = (CLK_HZ + PULSE_MAX_HZ - 1) / PULSE_MAX_HZ;

  localparam int          AW         = 8;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_SPAN   = 8'h04;
  localparam logic [7:0]  REG_ZERO   = 8'h08;
  localparam logic [7:0]  REG_NORM   = 8'h0c;
  localparam logic [7:0]  REG_CUTOFF = 8'h10;
  localparam logic [7:0]  REG_FILTK  = 8'h14;
  localparam logic [7:0]  REG_FACTOR = 8'h18;
  localparam logic [7:0]  REG_TIMERS = 8'h1c;
  localparam logic [7:0]  REG_POWER  = 8'h20;
  localparam logic [7:0]  REG_QTY    = 8'h24;
  localparam logic [7:0]  REG_STATUS = 8'h28;
  localparam logic [7:0]  REG_RATE   = 8'h2c;
  localparam logic [7:0]  REG_BTOT   = 8'h30;
  localparam logic [7:0]  REG_ATOT   = 8'h34;
  localparam logic [7:0]  REG_COMP   = 8'h38;

  localparam int          CTRL_AUTO  = 0;
  localparam int          CTRL_COMP  = 1;
  localparam int          CTRL_MODE  = 2;
  localparam int          CTRL_DP    = 4;
  localparam int          TMR_WAIT   = 8;
  localparam int          POW_FRAC   = 4;
  localparam logic [1:0]  MODE_LIN   = 2'h0;
  localparam logic [1:0]  MODE_SQRT  = 2'h1;
  localparam logic [1:0]  MODE_POW   = 2'h2;
  localparam logic [1:0]  MODE_BAD   = 2'h3;

  localparam logic [31:0] SPAN_MIN   = 32'h0000_03e8;
  localparam logic [31:0] SPAN_MAX   = 32'h1dcd_6500;
  localparam logic [31:0] ZERO_MAX   = 32'h1dcd_6500;
  localparam logic [6:0]  FILTK_MAX  = 7'h63;
  localparam logic [17:0] FACTOR_MIN = 18'h0_0001;
  localparam logic [17:0] FACTOR_MAX = 18'h3_0d40;
  localparam logic [6:0]  TMO_MAX    = 7'h63;
  localparam logic [3:0]  POW_MAX    = 4'h9;
  localparam logic [16:0] ONE        = 17'h1_0000;
  localparam logic signed [16:0] AVG3_MUL = 17'sh0_5556;

  localparam logic [5:0]  CTRL_RST   = 6'h00;
  localparam logic [31:0] SPAN_RST   = 32'h0000_2710;
  localparam logic [31:0] NORM_RST   = 32'h1000_0000;
  localparam logic [6:0]  FILTK_RST  = 7'h01;
  localparam logic [17:0] FACTOR_RST = 18'h0_0064;

  typedef enum logic [2:0] {
    BS_IDLE  = 3'b000,
    BS_RUN   = 3'b001,
    BS_PAUSE = 3'b010,
    BS_ALARM = 3'b011,
    BS_OVER  = 3'b100,
    BS_DONE  = 3'b101,
    BS_WAIT  = 3'b110
  } bst_batch_t;

  typedef enum logic [2:0] {
    CS_IDLE = 3'b000,
    CS_POW  = 3'b001,
    CS_RATE = 3'b010,
    CS_DIV  = 3'b011,
    CS_TOT  = 3'b100
  } bst_calc_t;

endpackage

/* hdl/bst_top.sv */
// Batch sequencer, rate calculation, filter, totaliser, pulse and alarm outputs.
// Assumes an APB master on ref_clk_i and keys and flow input synchronous to it.
`timescale 1ns/100ps
`default_nettype none

module bst_top #(
  parameter int unsigned SEC_CYCLES    = bst_pkg::SEC_CYC,
  parameter int unsigned SAMPLE_CYCLES = bst_pkg::SAMPLE_CYC,
  parameter int unsigned PLOW_CYCLES   = bst_pkg::PULSE_LOW_CYC,
  parameter int unsigned PPER_CYCLES   = bst_pkg::PULSE_PER_CYC
) (
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  // APB slave
  input  wire logic                   apb_psel_i,
  input  wire logic                   apb_penable_i,
  input  wire logic                   apb_pwrite_i,
  input  wire logic [bst_pkg::AW-1:0] apb_paddr_i,
  input  wire logic [31:0]            apb_pwdata_i,
  output logic [31:0]                 apb_prdata_o,
  output logic                        apb_pready_o,
  output logic                        apb_pslverr_o,
  // Operator keys, flow signal, analog sample
  input  wire logic                   run_key_i,
  input  wire logic                   stop_key_i,
  input  wire logic                   flow_i,
  input  wire logic [11:0]            adc_i,
  // Plant outputs
  output logic [1:0]                  relay_o,
  output logic                        eob_n_o,
  output logic                        alarm_n_o,
  output logic                        pulse_n_o
);
  import bst_pkg::*;

  typedef struct packed {
    logic [5:0]  ctrl;
    logic [31:0] span;
    logic [31:0] zero;
    logic [31:0] norm;
    logic [16:0] cutoff;
    logic [6:0]  filtk;
    logic [17:0] factor;
    logic [6:0]  tmo;
    logic [7:0]  rwait;
    logic [15:0] power;
    logic [31:0] qty;
    logic [31:0] prdata;
    logic        pslverr;
    logic        run_prev;
    logic        stop_prev;
    logic        flow_prev;
    logic [24:0] div;
    logic [21:0] smp;
    logic [6:0]  scnt;
    logic [7:0]  wcnt;
    bst_batch_t  bst;
    bst_calc_t   cs;
    logic [16:0] a;
    logic [16:0] pw;
    logic [3:0]  k;
    logic [31:0] filt;
    logic [31:0] mag;
    logic        neg;
    logic [6:0]  rem;
    logic [31:0] quo;
    logic [4:0]  dcnt;
    logic [39:0] resid;
    logic [31:0] btot;
    logic [31:0] atot;
    logic [15:0] pend;
    logic [18:0] pcnt;
    logic        plow;
    logic [31:0] ov0;
    logic [31:0] ov1;
    logic [31:0] ov2;
  } bst_state_t;

  bst_state_t q;
  bst_state_t n;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [16:0] bst_isqrt(input logic [33:0] v);
    logic [16:0] r;
    logic [35:0] t;
    r = '0;
    t = '0;
    for (int i = 16; i >= 0; i--) begin
      t = {19'h0_0000, r | (17'h0_0001 << i)};
      if (t * t <= {2'b00, v}) begin
        r = r | (17'h0_0001 << i);
      end
    end
    return r;
  endfunction

  logic               run_p;
  logic               stop_p;
  logic               flow_p;
  logic               sec_tick;
  logic               smp_tick;
  logic               timed_out;
  logic [1:0]         mode;
  logic [11:0]        nraw;
  logic [27:0]        nprod;
  logic [16:0]        norm_a;
  logic [33:0]        pmul;
  logic [16:0]        pdif;
  logic [28:0]        pint;
  logic [16:0]        f_sel;
  logic [48:0]        rprod;
  logic [31:0]        rate_c;
  logic [32:0]        fdif;
  logic [32:0]        fmag;
  logic [7:0]         r2;
  logic [9:0]         scale;
  logic [27:0]        thr;
  logic signed [33:0] osum;
  logic signed [50:0] oprod;
  logic [33:0]        avg;
  logic signed [34:0] target;
  logic               reached;
  logic               acc_inc;
  logic               pulse_start;
  logic [31:0]        rd_data;
  logic               acc_ok;

  assign run_p     = run_key_i & ~q.run_prev;
  assign stop_p    = stop_key_i & ~q.stop_prev;
  assign flow_p    = flow_i & ~q.flow_prev;
  assign sec_tick  = q.div == 25'(SEC_CYCLES - 1);
  assign smp_tick  = q.smp == 22'(SAMPLE_CYCLES - 1);
  assign timed_out = (q.tmo != 7'h00) && (q.scnt > q.tmo);
  assign mode      = q.ctrl[CTRL_MODE+:2];

  // Min offset in the low half, gain in the high half of NORM
  assign nraw   = (adc_i > q.norm[11:0]) ? adc_i - q.norm[11:0] : 12'h000;
  assign nprod  = nraw * q.norm[31:16];
  assign norm_a = (nprod[27:8] > {3'b000, ONE}) ? ONE : nprod[24:8];

  // Fractional power by interpolating between integer powers
  assign pmul = q.pw * q.a;
  assign pdif = q.pw - pmul[32:16];
  assign pint = pdif * q.power[15:POW_FRAC];

  always_comb begin
    case (mode)
      MODE_SQRT: f_sel = bst_isqrt({1'b0, q.a, 16'h0000});
      MODE_POW:  f_sel = q.pw;
      default:   f_sel = q.a;
    endcase
  end

  assign rprod  = q.span * f_sel;
  assign rate_c = rprod[47:16] + q.zero;
  assign fdif   = {1'b0, rate_c} - {1'b0, q.filt};
  assign fmag   = fdif[32] ? ~fdif + 33'h0_0000_0001 : fdif;
  assign r2     = {q.rem, q.mag[31]};

  // One display digit in units of 1e-5 rate units
  always_comb begin
    case (q.ctrl[CTRL_DP+:2])
      2'h0:    scale = 10'h3e8;
      2'h1:    scale = 10'h064;
      2'h2:    scale = 10'h00a;
      default: scale = 10'h001;
    endcase
  end
  assign thr = q.factor * scale;

  assign osum    = 34'($signed(q.ov0)) + 34'($signed(q.ov1)) + 34'($signed(q.ov2));
  assign oprod   = osum * AVG3_MUL;
  assign avg     = oprod[49:16];
  assign target  = $signed({3'b000, q.qty}) - (q.ctrl[CTRL_COMP] ? 35'($signed(avg)) : 35'sh0);
  assign reached = $signed({3'b000, q.btot}) >= target;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    rd_data = 32'h0000_0000;
    acc_ok  = 1'b1;
    case (apb_paddr_i)
      REG_CTRL: begin
        rd_data = {26'h000_0000, q.ctrl};
        acc_ok  = !apb_pwrite_i || apb_pwdata_i[CTRL_MODE+:2] != MODE_BAD;
      end
      REG_SPAN: begin
        rd_data = q.span;
        acc_ok  = !apb_pwrite_i || (apb_pwdata_i >= SPAN_MIN && apb_pwdata_i <= SPAN_MAX);
      end
      REG_ZERO: begin
        rd_data = q.zero;
        acc_ok  = !apb_pwrite_i || apb_pwdata_i <= ZERO_MAX;
      end
      REG_NORM:   rd_data = q.norm;
      REG_CUTOFF: begin
        rd_data = {15'h0000, q.cutoff};
        acc_ok  = !apb_pwrite_i || apb_pwdata_i <= {15'h0000, ONE};
      end
      REG_FILTK: begin
        rd_data = {25'h000_0000, q.filtk};
        acc_ok  = !apb_pwrite_i || (apb_pwdata_i != 32'h0 && apb_pwdata_i <= {25'h0, FILTK_MAX});
      end
      REG_FACTOR: begin
        rd_data = {14'h0000, q.factor};
        acc_ok  = !apb_pwrite_i || (apb_pwdata_i >= {14'h0, FACTOR_MIN} && apb_pwdata_i <= {14'h0, FACTOR_MAX});
      end
      REG_TIMERS: begin
        rd_data = {16'h0000, q.rwait, 1'b0, q.tmo};
        acc_ok  = !apb_pwrite_i || apb_pwdata_i[6:0] <= TMO_MAX;
      end
      REG_POWER: begin
        rd_data = {16'h0000, q.power};
        acc_ok  = !apb_pwrite_i || apb_pwdata_i[3:0] <= POW_MAX;
      end
      REG_QTY: begin
        rd_data = q.qty;
        acc_ok  = !apb_pwrite_i || !(q.bst == BS_RUN || q.bst == BS_OVER);
      end
      REG_STATUS: begin
        rd_data = {25'h000_0000, q.cs, q.bst, timed_out};
        acc_ok  = !apb_pwrite_i;
      end
      REG_RATE: begin
        rd_data = q.filt;
        acc_ok  = !apb_pwrite_i;
      end
      REG_BTOT: begin
        rd_data = q.btot;
        acc_ok  = !apb_pwrite_i;
      end
      REG_ATOT: begin
        rd_data = q.atot;
        acc_ok  = !apb_pwrite_i;
      end
      REG_COMP: begin
        rd_data = avg[31:0];
        acc_ok  = !apb_pwrite_i;
      end
      default: acc_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    n           = q;
    acc_inc     = 1'b0;
    pulse_start = 1'b0;
    n.run_prev  = run_key_i;
    n.stop_prev = stop_key_i;
    n.flow_prev = flow_i;
    n.div       = sec_tick ? 25'h000_0000 : q.div + 25'h000_0001;
    n.smp       = smp_tick ? 22'h00_0000 : q.smp + 22'h00_0001;
    if (flow_p) begin
      n.scnt = 7'h00;
    end else if (sec_tick && q.scnt != 7'h7f) begin
      n.scnt = q.scnt + 7'h01;
    end

    // Decode in setup so the access phase answers from flops
    if (apb_psel_i && !apb_penable_i) begin
      n.prdata  = rd_data;
      n.pslverr = !acc_ok;
    end
    if (apb_psel_i && apb_penable_i && apb_pwrite_i && !q.pslverr) begin
      case (apb_paddr_i)
        REG_CTRL:   n.ctrl   = apb_pwdata_i[5:0];
        REG_SPAN:   n.span   = apb_pwdata_i;
        REG_ZERO:   n.zero   = apb_pwdata_i;
        REG_NORM:   n.norm   = apb_pwdata_i;
        REG_CUTOFF: n.cutoff = apb_pwdata_i[16:0];
        REG_FILTK:  n.filtk  = apb_pwdata_i[6:0];
        REG_FACTOR: n.factor = apb_pwdata_i[17:0];
        REG_TIMERS: begin
          n.tmo   = apb_pwdata_i[6:0];
          n.rwait = apb_pwdata_i[TMR_WAIT+:8];
        end
        REG_POWER:  n.power  = apb_pwdata_i[15:0];
        REG_QTY:    n.qty    = apb_pwdata_i;
        default:    n.qty    = q.qty;
      endcase
    end

    // Samples arriving while busy are skipped; a long total loop stretches the interval
    case (q.cs)
      CS_IDLE: begin
        if (smp_tick) begin
          n.a  = norm_a;
          n.pw = ONE;
          n.k  = q.power[3:0];
          n.cs = (mode == MODE_POW) ? CS_POW : CS_RATE;
        end
      end
      CS_POW: begin
        if (q.k != 4'h0) begin
          n.pw = pmul[32:16];
          n.k  = q.k - 4'h1;
        end else begin
          n.pw = q.pw - pint[28:12];
          n.cs = CS_RATE;
        end
      end
      CS_RATE: begin
        if (f_sel >= q.cutoff) begin
          n.resid = q.resid + {8'h00, rate_c};
        end
        n.neg  = fdif[32];
        n.mag  = fmag[31:0];
        n.rem  = 7'h00;
        n.quo  = 32'h0000_0000;
        n.dcnt = 5'h1f;
        n.cs   = CS_DIV;
      end
      CS_DIV: begin
        n.mag = {q.mag[30:0], 1'b0};
        if (r2 >= {1'b0, q.filtk}) begin
          n.rem = 7'(r2 - {1'b0, q.filtk});
          n.quo = {q.quo[30:0], 1'b1};
        end else begin
          n.rem = r2[6:0];
          n.quo = {q.quo[30:0], 1'b0};
        end
        if (q.dcnt == 5'h00) begin
          n.filt = q.neg ? q.filt - n.quo : q.filt + n.quo;
          n.cs   = CS_TOT;
        end else begin
          n.dcnt = q.dcnt - 5'h01;
        end
      end
      CS_TOT: begin
        if (q.resid >= {12'h000, thr}) begin
          n.resid = q.resid - {12'h000, thr};
          n.atot  = q.atot + 32'h0000_0001;
          acc_inc = 1'b1;
          if (q.bst == BS_RUN || q.bst == BS_OVER || q.bst == BS_PAUSE || q.bst == BS_ALARM) begin
            n.btot = q.btot + 32'h0000_0001;
          end
        end else begin
          n.cs = CS_IDLE;
        end
      end
      default: n.cs = CS_IDLE;
    endcase

    // Pulse: low for PLOW cycles, one start per PPER cycles at most
    if (q.pcnt == 19'h0_0000) begin
      if (q.pend != 16'h0000) begin
        pulse_start = 1'b1;
        n.plow      = 1'b1;
        n.pcnt      = 19'(PPER_CYCLES - 1);
      end
    end else begin
      n.pcnt = q.pcnt - 19'h0_0001;
      if (q.pcnt == 19'(PPER_CYCLES - PLOW_CYCLES)) begin
        n.plow = 1'b0;
      end
    end
    if (acc_inc && !pulse_start && q.pend != 16'hffff) begin
      n.pend = q.pend + 16'h0001;
    end else if (!acc_inc && pulse_start) begin
      n.pend = q.pend - 16'h0001;
    end

    case (q.bst)
      BS_IDLE: begin
        if (run_p) begin
          n.bst  = BS_RUN;
          n.btot = 32'h0000_0000;
          n.scnt = 7'h00;
        end
      end
      BS_RUN: begin
        if (stop_p) begin
          n.bst = BS_PAUSE;
        end else if (reached) begin
          n.bst = (q.tmo != 7'h00) ? BS_OVER : BS_DONE;
          n.scnt = 7'h00;
        end else if (timed_out) begin
          n.bst = BS_ALARM;
        end
      end
      BS_PAUSE: begin
        if (run_p) begin
          n.bst  = BS_RUN;
          n.scnt = 7'h00;
        end else if (stop_p) begin
          n.bst = BS_IDLE;
        end
      end
      BS_ALARM: begin
        if (stop_p) begin
          n.bst = BS_PAUSE;
        end
      end
      BS_OVER: begin
        if (timed_out) begin
          n.bst = BS_DONE;
          n.ov0 = q.btot - q.qty;
          n.ov1 = q.ov0;
          n.ov2 = q.ov1;
        end
      end
      BS_DONE: begin
        if (q.ctrl[CTRL_AUTO]) begin
          n.bst  = BS_WAIT;
          n.wcnt = 8'h00;
        end else if (stop_p) begin
          n.bst = BS_IDLE;
        end
      end
      BS_WAIT: begin
        if (stop_p) begin
          n.bst = BS_IDLE;
        end else if (sec_tick) begin
          n.wcnt = q.wcnt + 8'h01;
          if (q.wcnt >= q.rwait) begin
            n.bst  = BS_RUN;
            n.btot = 32'h0000_0000;
            n.scnt = 7'h00;
          end
        end
      end
      default: n.bst = BS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q        <= '0;
      q.ctrl   <= CTRL_RST;
      q.span   <= SPAN_RST;
      q.norm   <= NORM_RST;
      q.filtk  <= FILTK_RST;
      q.factor <= FACTOR_RST;
      q.bst    <= BS_IDLE;
      q.cs     <= CS_IDLE;
    end else begin
      q <= n;
    end
  end

  assign apb_prdata_o  = q.prdata;
  assign apb_pready_o  = 1'b1;
  assign apb_pslverr_o = q.pslverr;
  assign relay_o       = {2{q.bst == BS_RUN}};
  assign eob_n_o       = !(q.bst == BS_DONE || q.bst == BS_WAIT);
  assign alarm_n_o     = !(q.bst == BS_ALARM);
  assign pulse_n_o     = !q.plow;

  ////////////////////////////////////////////////////////////////////////////

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  eob_hold_a: assert property (q.bst == BS_DONE && !stop_p |=> !eob_n_o) else $error("eob released");
  restart_a: assert property (q.bst == BS_WAIT && sec_tick && q.wcnt >= q.rwait && !stop_p
    |=> q.bst == BS_RUN && q.btot == 32'h0) else $error("no auto restart");
  relay_stop_a: assert property (q.bst == BS_RUN && stop_p |=> relay_o == 2'b00 && q.bst == BS_PAUSE)
    else $error("relays kept on STOP");
  alarm_need_a: assert property ($rose(q.bst == BS_ALARM) |-> $past(q.tmo) != 7'h00)
    else $error("alarm with zero timeout");
  alarm_ack_a: assert property (!alarm_n_o && stop_p |=> alarm_n_o && relay_o == 2'b00)
    else $error("alarm not released");
  cutoff_a: assert property (q.cs == CS_RATE && f_sel < q.cutoff |=> q.resid == $past(q.resid))
    else $error("integrated below cutoff");
  pend_keep_a: assert property (acc_inc && !pulse_start && q.pend != 16'hffff |=> q.pend == $past(q.pend) + 16'h1)
    else $error("pulse increment lost");
  pulse_low_a: assert property (!pulse_n_o |-> q.pcnt >= 19'(PPER_CYCLES - PLOW_CYCLES))
    else $error("pulse low too long");
  pulse_gap_a: assert property ($fell(pulse_n_o) |-> $past(q.pcnt) == 19'h0)
    else $error("pulses too close");
  filtk_err_a: assert property (apb_psel_i && !apb_penable_i && apb_pwrite_i && apb_paddr_i == REG_FILTK
    && (apb_pwdata_i == 32'h0 || apb_pwdata_i > 32'h63) |=> apb_pslverr_o) else $error("bad constant taken");
  over_rec_a: assert property (q.bst == BS_OVER && timed_out |=> q.ov0 == $past(q.btot) - $past(q.qty))
    else $error("overrun not recorded");

endmodule

`default_nettype wire

/* bench/bst_plant.sv */
// Plant model: operator RUN/STOP keys, flowmeter pulses and analog sensor.
// Assumes press() is called from a process synchronous to ref_clk_i.
`timescale 1ns/100ps
`default_nettype none
module bst_plant (
  // Clock and flow control from the bench
  input  wire logic  ref_clk_i,
  input  wire logic  flow_on_i,
  // Toward the block
  output logic        run_key_o,
  output logic        stop_key_o,
  output logic        flow_o,
  output logic [11:0] adc_o
);
  logic [3:0] div_q;
  initial begin
    run_key_o = 1'b0;
    stop_key_o = 1'b0;
    flow_o = 1'b0;
    div_q = 4'h0;
  end
  // Sensor reads zero when the line stops, so rate and pulses agree
  assign adc_o = flow_on_i ? 12'hfff : 12'h000;
  // Flow edge every 16 cycles, line idles low when stopped
  always @(posedge ref_clk_i) begin
    div_q <= div_q + 4'h1;
    flow_o <= flow_on_i & div_q[3];
  end
  // Key held 3 cycles so the block sees one clean rising edge
  task automatic press(input logic stop);
    @(posedge ref_clk_i);
    if (stop) stop_key_o <= 1'b1;
    else run_key_o <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    run_key_o <= 1'b0;
    stop_key_o <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

/* bench/test_batch_sequencer_totaliser.sv */
// Self-checking bench: APB register tasks, batch, auto restart, alarm, pulses.
// Assumes short second, sample and pulse counts set by parameters below.
`timescale 1ns/100ps
`default_nettype none
module test_batch_sequencer_totaliser;
  import bst_pkg::*;
  logic        ref_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, err, flow_on;
  logic        run_key, stop_key, flow, eob_n, alarm_n, pulse_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, bt;
  logic [11:0] adc;
  logic [1:0]  relay;
  int          fail_count, n_compared, cyc, n, plen, npulse, bad_pw;
  logic [7:0]  ra [4] = '{REG_SPAN, REG_FILTK, REG_FACTOR, REG_CTRL};
  logic [31:0] rv [4] = '{32'h0000_2710, 32'h0000_0001, 32'h0000_0064, 32'h0000_0000};
  logic [7:0]  ta [5] = '{REG_FILTK, REG_FILTK, REG_FACTOR, REG_SPAN, 8'hfc};
  logic [31:0] td [5] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_0000, 32'h0000_03e7, 32'h0000_0000};
  bst_top #(.SEC_CYCLES(50), .SAMPLE_CYCLES(100), .PLOW_CYCLES(4), .PPER_CYCLES(10)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .apb_psel_i(psel), .apb_penable_i(penable),
    .apb_pwrite_i(pwrite), .apb_paddr_i(paddr), .apb_pwdata_i(pwdata), .apb_prdata_o(prdata),
    .apb_pready_o(pready), .apb_pslverr_o(pslverr), .run_key_i(run_key), .stop_key_i(stop_key),
    .flow_i(flow), .adc_i(adc), .relay_o(relay), .eob_n_o(eob_n), .alarm_n_o(alarm_n), .pulse_n_o(pulse_n));
  bst_plant u_plant (.ref_clk_i(ref_clk_i), .flow_on_i(flow_on), .run_key_o(run_key),
    .stop_key_o(stop_key), .flow_o(flow), .adc_o(adc));
  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("Compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // Pulse width and count; hang guard well above the expected run
  always @(posedge ref_clk_i) begin
    if (!pulse_n) plen++;
    else begin
      if (plen != 0) npulse++;
      if (plen != 0 && plen != 4) bad_pw++;
      plen = 0;
    end
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    flow_on = 1'b0;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0000_0000);
      chk("reset value", rv[i], rd);
    end
    foreach (ta[i]) begin
      apb(1'b1, ta[i], td[i]);
      chk("refused write", 32'h0000_0001, {31'h0, err});
    end
    apb(1'b1, REG_SPAN, 32'h0004_93e0);
    apb(1'b1, REG_CUTOFF, 32'h0000_1000);
    apb(1'b1, REG_QTY, 32'h0000_0014);
    apb(1'b1, REG_TIMERS, 32'h0000_0101);
    apb(1'b1, REG_CTRL, 32'h0000_0003);
    chk("ctrl write", 32'h0000_0000, {31'h0, err});
    flow_on <= 1'b1;
    u_plant.press(1'b0);
    chk("relay run", 32'h0000_0003, {30'h0, relay});
    n = 0;
    while (relay !== 2'b00 && n++ < 3000) @(negedge ref_clk_i);
    chk("relay at quantity", 32'h0000_0000, {30'h0, relay});
    @(posedge ref_clk_i);
    apb(1'b0, REG_BTOT, 32'h0000_0000);
    chk("batch total reached", 32'h0000_0001, {31'h0, rd >= 32'd20});
    flow_on <= 1'b0;
    n = 0;
    while (eob_n !== 1'b0 && n++ < 400) @(negedge ref_clk_i);
    chk("end of batch", 32'h0000_0000, {31'h0, eob_n});
    // Overrun history holds only this batch, so the average is a third of it
    @(posedge ref_clk_i);
    apb(1'b0, REG_BTOT, 32'h0000_0000);
    bt = rd;
    apb(1'b0, REG_COMP, 32'h0000_0000);
    chk("overrun average", ((bt - 32'h0000_0014) * 32'h0000_5556) >> 16, rd);
    n = 0;
    while (relay !== 2'b11 && n++ < 300) @(negedge ref_clk_i);
    chk("auto restart relay", 32'h0000_0003, {30'h0, relay});
    chk("auto restart eob", 32'h0000_0001, {31'h0, eob_n});
    @(posedge ref_clk_i);
    flow_on <= 1'b1;
    u_plant.press(1'b1);
    chk("relay pause", 32'h0000_0000, {30'h0, relay});
    u_plant.press(1'b0);
    chk("relay resume", 32'h0000_0003, {30'h0, relay});
    u_plant.press(1'b1);
    u_plant.press(1'b1);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("abort to idle", 32'h0000_0000, {29'h0, rd[3:1]});
    flow_on <= 1'b0;
    u_plant.press(1'b0);
    n = 0;
    while (alarm_n !== 1'b0 && n++ < 300) @(negedge ref_clk_i);
    chk("flow alarm", 32'h0000_0000, {31'h0, alarm_n});
    chk("relay on alarm", 32'h0000_0000, {30'h0, relay});
    u_plant.press(1'b1);
    chk("alarm released", 32'h0000_0001, {31'h0, alarm_n});
    // Full-scale input, constant 1: the rate register follows each sample exactly
    flow_on <= 1'b1;
    repeat (250) @(posedge ref_clk_i);
    apb(1'b0, REG_RATE, 32'h0000_0000);
    chk("rate linear", 32'h0004_9396, rd);
    apb(1'b1, REG_CTRL, 32'h0000_0007);
    repeat (250) @(posedge ref_clk_i);
    apb(1'b0, REG_RATE, 32'h0000_0000);
    chk("rate square law", 32'h0004_93b6, rd);
    apb(1'b1, REG_POWER, 32'h0000_0002);
    apb(1'b1, REG_CTRL, 32'h0000_000b);
    repeat (250) @(posedge ref_clk_i);
    apb(1'b0, REG_RATE, 32'h0000_0000);
    chk("rate power", 32'h0004_934d, rd);
    chk("pulse width errors", 32'h0000_0000, bad_pw);
    chk("pulses seen", 32'h0000_0001, {31'h0, npulse >= 20});
    report_and_stop();
  end
endmodule
`default_nettype wire
